// ---- inc/psis_pkg.sv ----
// Shared types of the port status block
package psis_pkg;
  typedef logic [15:0] psis_half_type;
  typedef logic [31:0] psis_word_type;
  typedef logic [11:0] psis_addr_type;
  typedef logic [9:0]  psis_idx_type;
  typedef logic [3:0]  psis_strb_type;
endpackage : psis_pkg

// ---- inc/psis_reg_if.sv ----
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface psis_reg_if;
  import psis_pkg::*;
  logic          wr_en;
  psis_addr_type wr_addr;
  psis_word_type wr_data;
  psis_strb_type wr_strb;
  logic          wr_hit;
  psis_addr_type rd_addr;
  psis_word_type rd_data;
  logic          rd_hit;

  // Bus side issues accesses, register side decodes them
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : psis_reg_if

// ---- inc/psis_regs.svh ----
// Register indices, field positions, masks and reset values of the port status block
`ifndef PSIS_REGS_SVH
`define PSIS_REGS_SVH

// Word indices; the byte address is four times the index
`define PSIS_IDX_SUMMARY 10'h050
`define PSIS_IDX_LIVE 10'h052
`define PSIS_IDX_LATCHED 10'h054
`define PSIS_IDX_IRQ_EN 10'h056
`define PSIS_IDX_CTRL 10'h05E

// Summary bit positions
`define PSIS_SUM_PORT 9
`define PSIS_SUM_TRACE 7
`define PSIS_SUM_ALARM 6
`define PSIS_SUM_LINK 5
`define PSIS_SUM_TESTER 4
`define PSIS_SUM_FRAMER 0

// Live, latched and enable bit positions
`define PSIS_ST_OVERLOAD 2
`define PSIS_ST_LOCK 1
`define PSIS_ST_PERF 0
`define PSIS_LAT_RXCLK 7
`define PSIS_LAT_TXCLK 6

// Control register bit positions
`define PSIS_CTRL_GLOBAL_EN 0
`define PSIS_CTRL_PERF_REQ 1

// Implemented-bit masks
`define PSIS_LIVE_MASK 16'h0007
`define PSIS_LAT_MASK 16'h00C7
`define PSIS_IEN_MASK 16'h0007
`define PSIS_CTRL_MASK 16'h0003

// Reset values
`define PSIS_LIVE_RESET 16'h0000
`define PSIS_LAT_RESET 16'h0000
`define PSIS_IEN_RESET 16'h0000
`define PSIS_CTRL_RESET 16'h0000

// Bus response codes
`define PSIS_RESP_OKAY 2'h0
`define PSIS_RESP_SLVERR 2'h2

`endif

// ---- logic/psis_activity_det.sv ----
// Per-bit toggle detector that flags activity on sampled clock inputs
`timescale 1ns/1ps
module psis_activity_det
#(
  parameter int unsigned WIDTH = 3
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] toggle
);
  logic             armed_q;
  logic [WIDTH-1:0] prev_q;

  // Arm one cycle after reset so a static level is not mistaken for an edge
  always_ff @(posedge clk_sys)
  begin
    armed_q <= ~reset;
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // Previous sample of this input
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          prev_q[gi] <= 1'b0;
        else
          prev_q[gi] <= level[gi];
      end
      assign toggle[gi] = armed_q & (level[gi] ^ prev_q[gi]);
    end
  endgenerate
endmodule : psis_activity_det

// ---- logic/psis_axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`include "psis_regs.svh"
module psis_axil_slave
  import psis_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    reset,
  input  psis_addr_type s_axi_awaddr,
  input  wire logic    s_axi_awvalid,
  output logic         s_axi_awready,
  input  psis_word_type s_axi_wdata,
  input  psis_strb_type s_axi_wstrb,
  input  wire logic    s_axi_wvalid,
  output logic         s_axi_wready,
  output logic [1:0]   s_axi_bresp,
  output logic         s_axi_bvalid,
  input  wire logic    s_axi_bready,
  input  psis_addr_type s_axi_araddr,
  input  wire logic    s_axi_arvalid,
  output logic         s_axi_arready,
  output psis_word_type s_axi_rdata,
  output logic [1:0]   s_axi_rresp,
  output logic         s_axi_rvalid,
  input  wire logic    s_axi_rready,
  psis_reg_if.bus      rif
);
  psis_addr_type awaddr_q;
  psis_addr_type araddr_q;
  psis_word_type wdata_q;
  psis_strb_type wstrb_q;
  logic          rd_pend_q;

  // Address and data are taken independently; both must be held before the write
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSIS_RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (rif.wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rif.wr_hit ? `PSIS_RESP_OKAY : `PSIS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign rif.wr_en   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;

  // Reads take one cycle of decode after the address is accepted
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `PSIS_RESP_OKAY;
      s_axi_rdata   <= '0;
      araddr_q      <= '0;
      rd_pend_q     <= 1'b0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        araddr_q      <= s_axi_araddr;
        rd_pend_q     <= 1'b1;
      end
      if (rd_pend_q)
      begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rif.rd_hit ? rif.rd_data : '0;
        s_axi_rresp  <= rif.rd_hit ? `PSIS_RESP_OKAY : `PSIS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  assign rif.rd_addr = araddr_q;

  // Read answer arrives exactly two edges after the address is taken
  read_latency_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer not two cycles after address");
  // Write answer holds until the master takes it
  write_resp_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule : psis_axil_slave

// ---- logic/psis_top.sv ----
// Port status, latched status, enables and interrupt summary of one line port
//
// Function
// (R1) Summary bit 7 follows trace block requests
// (R2) Summary bit 6 follows alarm channel requests
// (R3) Summary bit 5 follows link controller requests
// (R4) Summary bit 4 follows bit tester requests
// (R5) Summary bit 0 follows the active framer
// (R6) Interrupt when any summary and global enable
// (R7) Live bit 2 shows driver overload
// (R8) Live bit 1 shows receive lock lost
// (R9) Live bit 0 ANDs active update completions
// (R10) Host holds update request until done reads
// (R11) Latched bit 7 on receive clock activity
// (R12) Latched bit 6 on transmit clock activity
// (R13) Latched bit 2 on overload rising edge
// (R14) Latched bit 1 on lock-lost rising edge
// (R15) Latched bit 0 on update-done rising edge
// (R16) Enabled latched bit sets port summary bit
// (R17) Interrupt needs latched, enable, global enable
// (R18) Status interrupt enables reset to zero
// (R19) Summary bit 9 plus global drives interrupt
// (R20) Latched bits clear by one, summaries read-only
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "psis_regs.svh"
module psis_top
  import psis_pkg::*;
#(
  parameter int unsigned PERF_N = 4
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  psis_addr_type          s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  psis_word_type          s_axi_wdata,
  input  psis_strb_type          s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  psis_addr_type          s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output psis_word_type          s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              trace_block_summary,
  input  wire logic              alarm_channel_summary,
  input  wire logic              link_ctrl_summary,
  input  wire logic              tester_summary,
  input  wire logic              ds3_framer_summary,
  input  wire logic              e3_framer_summary,
  input  wire logic              e3_mode,
  input  wire logic              tx_driver_overload,
  input  wire logic              rx_lock_lost,
  input  wire logic [PERF_N-1:0] perf_done_vec,
  input  wire logic [PERF_N-1:0] perf_active_vec,
  input  wire logic              rx_line_clock_in,
  input  wire logic              rx_recovered_clock,
  input  wire logic              tx_clock_in,
  output logic                   perf_update_request,
  output logic                   port_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and register strobes

  psis_reg_if rif ();

  psis_axil_slave u_axil (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif.bus)
  );

  psis_half_type live_q;
  psis_half_type live_d;
  psis_half_type lat_q;
  psis_half_type lat_set;
  psis_half_type lat_clr;
  psis_half_type ien_q;
  psis_half_type ctrl_q;
  psis_half_type summ;
  psis_half_type wmask;
  psis_idx_type  wr_idx;
  psis_idx_type  rd_idx;
  logic [2:0]    clk_act;
  logic          glob_en;
  logic          port_irq_q;

  assign wr_idx  = rif.wr_addr[11:2];
  assign rd_idx  = rif.rd_addr[11:2];
  assign wmask   = {{8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
  assign glob_en = ctrl_q[`PSIS_CTRL_GLOBAL_EN];

  // Only the five documented words answer; everything else gets an error response
  always_comb
  begin
    case (wr_idx)
      `PSIS_IDX_SUMMARY,
      `PSIS_IDX_LIVE,
      `PSIS_IDX_LATCHED,
      `PSIS_IDX_IRQ_EN,
      `PSIS_IDX_CTRL: rif.wr_hit = 1'b1;
      default:        rif.wr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock activity and live status

  // Clock pins are sampled as data; any toggle counts as activity
  psis_activity_det #(
    .WIDTH (3)
  ) u_act (
    .clk_sys (clk_sys),
    .reset   (reset),
    .level   ({tx_clock_in, rx_recovered_clock, rx_line_clock_in}),
    .toggle  (clk_act)
  );

  // Update is done only when every active source has finished; none active means not done
  always_comb
  begin
    live_d                    = `PSIS_LIVE_RESET;
    live_d[`PSIS_ST_OVERLOAD] = tx_driver_overload;                          // [R7]
    live_d[`PSIS_ST_LOCK]     = rx_lock_lost;                                // [R8]
    live_d[`PSIS_ST_PERF]     = (&(perf_done_vec | ~perf_active_vec))
                                & (|perf_active_vec);                        // [R9]
  end

  // Live register, one cycle behind the pins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      live_q <= `PSIS_LIVE_RESET;
    else
      live_q <= live_d & `PSIS_LIVE_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latched status

  // Set sources: activity pulses and rising edges of the live bits
  always_comb
  begin
    lat_set                    = `PSIS_LAT_RESET;
    lat_set[`PSIS_LAT_RXCLK]   = clk_act[0] | clk_act[1];                    // [R11]
    lat_set[`PSIS_LAT_TXCLK]   = clk_act[2];                                 // [R12]
    lat_set[`PSIS_ST_OVERLOAD] = live_d[`PSIS_ST_OVERLOAD]
                                 & ~live_q[`PSIS_ST_OVERLOAD];               // [R13]
    lat_set[`PSIS_ST_LOCK]     = live_d[`PSIS_ST_LOCK] & ~live_q[`PSIS_ST_LOCK]; // [R14]
    lat_set[`PSIS_ST_PERF]     = live_d[`PSIS_ST_PERF] & ~live_q[`PSIS_ST_PERF]; // [R15]
  end

  // Write-one-to-clear mask, honouring the byte strobes
  always_comb
  begin
    lat_clr = '0;
    if (rif.wr_en && (wr_idx == `PSIS_IDX_LATCHED))
      lat_clr = rif.wr_data[15:0] & wmask;                                   // [R20]
  end

  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      lat_q <= `PSIS_LAT_RESET;
    else
      lat_q <= ((lat_q & ~lat_clr) | lat_set) & `PSIS_LAT_MASK;             // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software controlled registers

  // Interrupt enables, all off out of reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ien_q <= `PSIS_IEN_RESET;                                              // [R18]
    else if (rif.wr_en && (wr_idx == `PSIS_IDX_IRQ_EN))
      ien_q <= ((ien_q & ~wmask) | (rif.wr_data[15:0] & wmask)) & `PSIS_IEN_MASK;
  end

  // Global enable and update request; the request is a plain level the host holds
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl_q <= `PSIS_CTRL_RESET;
    else if (rif.wr_en && (wr_idx == `PSIS_IDX_CTRL))
      ctrl_q <= ((ctrl_q & ~wmask) | (rif.wr_data[15:0] & wmask)) & `PSIS_CTRL_MASK;
  end

  // Host keeps this high until the done bit reads high; it is not cleared here
  assign perf_update_request = ctrl_q[`PSIS_CTRL_PERF_REQ];                 // [R10]

  ////////////////////////////////////////////////////////////////////////////////
  // Summary and interrupt

  // Summary follows its sources with no storage, so it cannot go stale
  always_comb
  begin
    summ                   = '0;
    summ[`PSIS_SUM_TRACE]  = trace_block_summary;                            // [R1]
    summ[`PSIS_SUM_ALARM]  = alarm_channel_summary;                          // [R2]
    summ[`PSIS_SUM_LINK]   = link_ctrl_summary;                              // [R3]
    summ[`PSIS_SUM_TESTER] = tester_summary;                                 // [R4]
    summ[`PSIS_SUM_FRAMER] = e3_mode ? e3_framer_summary : ds3_framer_summary; // [R5]
    summ[`PSIS_SUM_PORT]   = |(lat_q & ien_q & `PSIS_IEN_MASK);              // [R16] [R19]
  end

  // Registered so the pin is glitch free; costs one cycle of latency
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      port_irq_q <= 1'b0;
    else
      port_irq_q <= (|summ) & glob_en;                                       // [R6] [R17]
  end

  assign port_irq = port_irq_q;

  // Read mux; the summary word ignores writes
  always_comb
  begin
    rif.rd_hit  = 1'b1;
    rif.rd_data = '0;
    case (rd_idx)
      `PSIS_IDX_SUMMARY: rif.rd_data = {16'h0000, summ};                     // [R20]
      `PSIS_IDX_LIVE:    rif.rd_data = {16'h0000, live_q};
      `PSIS_IDX_LATCHED: rif.rd_data = {16'h0000, lat_q};
      `PSIS_IDX_IRQ_EN:  rif.rd_data = {16'h0000, ien_q};
      `PSIS_IDX_CTRL:    rif.rd_data = {16'h0000, ctrl_q};
      default:           rif.rd_hit  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // An enabled latched event followed through to the pin
  sequence overload_event_s;
    $rose(lat_q[`PSIS_ST_OVERLOAD]) ##0 ien_q[`PSIS_ST_OVERLOAD];
  endsequence
  sequence lock_event_s;
    $rose(lat_q[`PSIS_ST_LOCK]) ##0 ien_q[`PSIS_ST_LOCK];
  endsequence

  trace_irq_a: assert property (trace_block_summary && glob_en |=> port_irq) // [R1]
    else $error("trace summary did not raise interrupt");
  alarm_irq_a: assert property (alarm_channel_summary && glob_en |=> port_irq) // [R2]
    else $error("alarm summary did not raise interrupt");
  link_irq_a: assert property (link_ctrl_summary && glob_en |=> port_irq) // [R3]
    else $error("link controller summary did not raise interrupt");
  tester_irq_a: assert property (tester_summary && glob_en |=> port_irq) // [R4]
    else $error("tester summary did not raise interrupt");
  framer_select_a: assert property (((e3_mode && e3_framer_summary) // [R5]
    || (!e3_mode && ds3_framer_summary)) && glob_en |=> port_irq)
    else $error("active framer summary did not raise interrupt");
  global_gate_a: assert property (!glob_en |=> !port_irq) // [R6]
    else $error("interrupt raised while global enable is off");
  overload_live_a: assert property (live_q[`PSIS_ST_OVERLOAD] == $past(tx_driver_overload)) // [R7]
    else $error("overload live bit does not follow the monitor");
  lock_live_a: assert property (live_q[`PSIS_ST_LOCK] == $past(rx_lock_lost)) // [R8]
    else $error("lock live bit does not follow the recovery loop");
  perf_and_a: assert property (live_q[`PSIS_ST_PERF] // [R9]
    |-> (&($past(perf_done_vec) | ~$past(perf_active_vec))) && (|$past(perf_active_vec)))
    else $error("update done shown before all active updates finished");
  rxclk_latch_a: assert property (|clk_act[1:0] |=> lat_q[`PSIS_LAT_RXCLK]) // [R11]
    else $error("receive clock activity not latched");
  txclk_latch_a: assert property (clk_act[2] |=> lat_q[`PSIS_LAT_TXCLK]) // [R12]
    else $error("transmit clock activity not latched");
  overload_rise_a: assert property ($rose(live_q[`PSIS_ST_OVERLOAD]) // [R13]
    |-> lat_q[`PSIS_ST_OVERLOAD])
    else $error("overload rise not latched");
  lock_rise_a: assert property ($rose(live_q[`PSIS_ST_LOCK]) |-> lat_q[`PSIS_ST_LOCK]) // [R14]
    else $error("lock loss rise not latched");
  perf_rise_a: assert property ($rose(live_q[`PSIS_ST_PERF]) |-> lat_q[`PSIS_ST_PERF]) // [R15]
    else $error("update done rise not latched");
  port_summary_a: assert property (lat_q[`PSIS_ST_PERF] && ien_q[`PSIS_ST_PERF] // [R16]
    |-> summ[`PSIS_SUM_PORT])
    else $error("enabled latched bit missing from port summary");
  event_irq_a: assert property ((overload_event_s or lock_event_s) ##0 glob_en // [R17]
    |=> port_irq)
    else $error("enabled latched event did not raise interrupt");
  enable_reset_a: assert property (disable iff (1'b0) $past(reset) // [R18]
    |-> ien_q == `PSIS_IEN_RESET)
    else $error("interrupt enables not cleared by reset");
  port_summary_irq_a: assert property (summ[`PSIS_SUM_PORT] && glob_en |=> port_irq) // [R19]
    else $error("port summary did not raise interrupt");
  latch_hold_a: assert property (lat_q[`PSIS_ST_LOCK] && !lat_clr[`PSIS_ST_LOCK] // [R20]
    |=> lat_q[`PSIS_ST_LOCK])
    else $error("latched bit dropped without a clear");
  unmasked_quiet_a: assert property (!(|(lat_q & ien_q)) |-> !summ[`PSIS_SUM_PORT]) // [R16]
    else $error("port summary set without an enabled latched bit");

endmodule : psis_top

// ---- tb/test_psis_top.sv ----
// Self-checking bench for the port status and interrupt summary block
`timescale 1ns/1ps
`include "psis_regs.svh"
module test_psis_top
  import psis_pkg::*;
;
  localparam int A_SUM  = 4 * `PSIS_IDX_SUMMARY;
  localparam int A_LIVE = 4 * `PSIS_IDX_LIVE;
  localparam int A_LAT  = 4 * `PSIS_IDX_LATCHED;
  localparam int A_IEN  = 4 * `PSIS_IDX_IRQ_EN;
  localparam int A_CTL  = 4 * `PSIS_IDX_CTRL;

  logic          clk_sys, reset;
  psis_addr_type s_axi_awaddr, s_axi_araddr;
  psis_word_type s_axi_wdata, s_axi_rdata, rd_d;
  psis_strb_type s_axi_wstrb;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
  logic          trace_block_summary, alarm_channel_summary, link_ctrl_summary;
  logic          tester_summary, ds3_framer_summary, e3_framer_summary, e3_mode;
  logic          tx_driver_overload, rx_lock_lost, perf_update_request, port_irq;
  logic [3:0]    perf_done_vec, perf_active_vec;
  logic          rx_line_clock_in, rx_recovered_clock, tx_clock_in;
  int            miscompares, cmp_count;
  // Source order: trace, alarm, link, tester, ds3 framer, e3 framer, e3 mode
  logic [6:0]    src_tab [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h05, 7'h03, 7'h02};
  logic [15:0]   sum_tab [8] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010,
                                 16'h0001, 16'h0000, 16'h0001, 16'h0000};

`define CMP(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      miscompares++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end

  psis_top psis_top_inst (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Watchdog sized well beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data offered together, held until each is taken
  task automatic wr(input int a, input int d, input logic [1:0] er = `PSIS_RESP_OKAY);
    @(posedge clk_sys);
    s_axi_awaddr  <= a[11:0];
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CMP("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask : wr

  // AXI4-Lite read: rready held until rvalid is sampled high
  task automatic rd(input int a, output psis_word_type d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a[11:0];
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Read one register and compare word and response
  task automatic chk(input int a, input int e, input string nm);
    rd(a, rd_d, rsp);
    `CMP(nm, psis_word_type'(e), rd_d)
    `CMP("resp", `PSIS_RESP_OKAY, rsp)
  endtask : chk

  // Toggle one sampled clock slowly enough for the activity detector
  task automatic tog(input int k);
    repeat (4)
    begin
      repeat (3) @(posedge clk_sys);
      if (k == 0) rx_line_clock_in <= ~rx_line_clock_in;
      else if (k == 1) rx_recovered_clock <= ~rx_recovered_clock;
      else tx_clock_in <= ~tx_clock_in;
    end
  endtask : tog

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {trace_block_summary, alarm_channel_summary, link_ctrl_summary, tester_summary} = '0;
    {ds3_framer_summary, e3_framer_summary, e3_mode, tx_driver_overload, rx_lock_lost} = '0;
    {perf_done_vec, perf_active_vec} = '0;
    {rx_line_clock_in, rx_recovered_clock, tx_clock_in} = '0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    chk(A_IEN, 0, "irq_en");
    chk(A_LAT, 0, "latched");
    rd(12'h3FC, rd_d, rsp);
    `CMP("unmapped_resp", `PSIS_RESP_SLVERR, rsp)
    `CMP("unmapped_data", 0, rd_d)
    wr(12'h3FC, 0, `PSIS_RESP_SLVERR);
    wr(A_CTL, 1);
    // Every summary source, both framers under both modes
    for (int i = 0; i < 8; i++)
    begin
      {trace_block_summary, alarm_channel_summary, link_ctrl_summary, tester_summary,
       ds3_framer_summary, e3_framer_summary, e3_mode} <= src_tab[i];
      chk(A_SUM, sum_tab[i], "summary");
      `CMP("irq", sum_tab[i] != 0, port_irq)
    end
    trace_block_summary <= 1'b1;
    wr(A_CTL, 0);
    repeat (2) @(posedge clk_sys);
    `CMP("irq_masked", 1'b0, port_irq)
    trace_block_summary <= 1'b0;
    // Lock loss, enable gating and write-one-to-clear
    rx_lock_lost <= 1'b1;
    chk(A_LIVE, 16'h0002, "live");
    chk(A_LAT, 16'h0002, "latched");
    chk(A_SUM, 0, "summary");
    wr(A_IEN, 16'h0002);
    chk(A_SUM, 16'h0200, "summary");
    wr(A_SUM, 0);
    chk(A_SUM, 16'h0200, "summary");
    wr(A_CTL, 1);
    repeat (2) @(posedge clk_sys);
    `CMP("irq_lock", 1'b1, port_irq)
    tx_driver_overload <= 1'b1;
    chk(A_LIVE, 16'h0006, "live");
    chk(A_LAT, 16'h0006, "latched");
    wr(A_LAT, 16'h0002);
    chk(A_LAT, 16'h0004, "latched");
    chk(A_SUM, 0, "summary");
    `CMP("irq_clr", 1'b0, port_irq)
    // Update done is an AND over active sources only
    perf_active_vec <= 4'b0011;
    perf_done_vec   <= 4'b1101;
    chk(A_LIVE, 16'h0006, "live");
    perf_done_vec <= 4'b0011;
    chk(A_LIVE, 16'h0007, "live");
    chk(A_LAT, 16'h0005, "latched");
    wr(A_IEN, 16'h0007);
    wr(A_LAT, 16'h00C7);
    chk(A_LAT, 0, "latched");
    // Clock activity latches, which never reach the summary
    tog(0);
    chk(A_LAT, 16'h0080, "latched");
    wr(A_LAT, 16'h0080);
    tog(1);
    chk(A_LAT, 16'h0080, "latched");
    tog(2);
    chk(A_LAT, 16'h00C0, "latched");
    chk(A_SUM, 0, "summary");
    rx_lock_lost  <= 1'b0;
    perf_done_vec <= 4'b0000;
    wr(A_CTL, 3);
    repeat (2) @(posedge clk_sys);
    `CMP("perf_req", 1'b1, perf_update_request)
    chk(A_LIVE, 16'h0004, "live");
    // Sub-blocks finish; the request stays up until done reads high
    rx_lock_lost  <= 1'b1;
    perf_done_vec <= 4'b0011;
    chk(A_LIVE, 16'h0007, "live");
    chk(A_LAT, 16'h00C3, "latched");
    `CMP("irq_event", 1'b1, port_irq)
    wr(A_CTL, 1);
    repeat (2) @(posedge clk_sys);
    `CMP("perf_req", 1'b0, perf_update_request)
    wrap_up();
  end
endmodule : test_psis_top
